// ==== hw/icr_pkg.sv ====
package icr_pkg;
    localparam int          BYTE_W          = 8;
    localparam int          NUM_BYTES       = 12;
    localparam int          PTR_W           = 4;
    localparam logic [3:0]  PTR_SIG         = 4'h0;
    localparam logic [3:0]  PTR_LOAD        = 4'h1;
    localparam logic [3:0]  PTR_LOOPBACK_EMPHASIS_CTRL        = 4'h2;
    localparam logic [3:0]  PTR_CHANNEL_INPUT_DISABLE       = 4'h3;
    localparam logic [3:0]  PTR_CHANNEL_OUTPUT_DISABLE      = 4'h4;
    localparam logic [3:0]  PTR_RESTART     = 4'h5;
    localparam logic [3:0]  PTR_PWR         = 4'h6;
    localparam logic [3:0]  PTR_RECEIVER_DETECT_ENABLE        = 4'h7;
    localparam logic [3:0]  PTR_GRPA        = 4'h8;
    localparam logic [3:0]  PTR_GRPB        = 4'h9;
    localparam logic [3:0]  PTR_RSVD        = 4'hA;
    localparam logic [3:0]  PTR_VTH         = 4'hB;
    localparam logic [3:0]  PTR_LAST        = 4'hB;
    localparam logic [1:0]  ADDR_HIGH_FIXED = 2'h3;
    localparam logic [1:0]  ADDR_MID_FIXED  = 2'h0;
    localparam logic [7:0]  CHANNEL_INPUT_DISABLE_RESET     = 8'h00;
    localparam logic [7:0]  CHANNEL_OUTPUT_DISABLE_RESET    = 8'h00;
    localparam logic [7:0]  RSVD_RESET      = 8'h00;
    localparam logic [7:0]  VTH_RESET       = 8'hEF;
    localparam logic [7:0]  LOOPBACK_EMPHASIS_CTRL_WMASK      = 8'hFC;
    localparam logic [2:0]  BIT_LAST        = 3'h7;
    typedef enum logic [2:0] {
        ICR_IDLE,
        ICR_ADDR,
        ICR_ACK,
        ICR_WRX,
        ICR_RTX,
        ICR_RACK,
        ICR_SKIP
    } icr_state_e;
endpackage

// ==== hw/icr_regfile.sv ====
`timescale 1ns/1ns
// Writable configuration bytes; read data come out of a register.
module icr_regfile (
    input  wire logic                               clock,
    input  wire logic                               rst_n,
    input  wire logic                               init,
    input  wire logic [7:0]                         init_loopback_emphasis_ctrl,
    input  wire logic [7:0]                         init_restart,
    input  wire logic [7:0]                         init_pwr,
    input  wire logic [7:0]                         init_receiver_detect_enable,
    input  wire logic [7:0]                         init_grpa,
    input  wire logic [7:0]                         init_grpb,
    input  wire logic                               wr,
    input  wire logic [icr_pkg::PTR_W-1:0]          wr_ptr,
    input  wire logic [7:0]                         wr_data,
    input  wire logic [icr_pkg::PTR_W-1:0]          rd_ptr,
    input  wire logic [7:0]                         sig_live,
    input  wire logic [7:0]                         load_live,
    output logic      [7:0]                         rd_data,
    output logic      [8*icr_pkg::NUM_BYTES-1:0]    regs
);
    logic [7:0] mem_q [icr_pkg::NUM_BYTES];

    // Byte zero and one are live status and never stored.
    genvar g;
    for (g = 0; g < icr_pkg::NUM_BYTES; g++) begin : g_byte
        assign regs[8*g +: 8] = mem_q[g];
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                if (g == int'(icr_pkg::PTR_CHANNEL_INPUT_DISABLE))
                    mem_q[g] <= icr_pkg::CHANNEL_INPUT_DISABLE_RESET;
                else if (g == int'(icr_pkg::PTR_VTH))
                    mem_q[g] <= icr_pkg::VTH_RESET;
                else if (g == int'(icr_pkg::PTR_CHANNEL_OUTPUT_DISABLE))
                    mem_q[g] <= icr_pkg::CHANNEL_OUTPUT_DISABLE_RESET;
                else
                    mem_q[g] <= icr_pkg::RSVD_RESET;
            end else if (init) begin
                if (g == int'(icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL))
                    mem_q[g] <= init_loopback_emphasis_ctrl;
                else if (g == int'(icr_pkg::PTR_RESTART))
                    mem_q[g] <= init_restart;
                else if (g == int'(icr_pkg::PTR_PWR))
                    mem_q[g] <= init_pwr;
                else if (g == int'(icr_pkg::PTR_RECEIVER_DETECT_ENABLE))
                    mem_q[g] <= init_receiver_detect_enable;
                else if (g == int'(icr_pkg::PTR_GRPA))
                    mem_q[g] <= init_grpa;
                else if (g == int'(icr_pkg::PTR_GRPB))
                    mem_q[g] <= init_grpb;
            end else if (wr && int'(wr_ptr) == g) begin
                if (g == int'(icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL))
                    mem_q[g] <= (wr_data & icr_pkg::LOOPBACK_EMPHASIS_CTRL_WMASK) |
                                (mem_q[g] & ~icr_pkg::LOOPBACK_EMPHASIS_CTRL_WMASK);
                else if (g != int'(icr_pkg::PTR_SIG) && g != int'(icr_pkg::PTR_LOAD))
                    mem_q[g] <= wr_data;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_ptr == icr_pkg::PTR_SIG) begin
            rd_data <= sig_live;
        end else if (rd_ptr == icr_pkg::PTR_LOAD) begin
            rd_data <= load_live;
        end else if (rd_ptr <= icr_pkg::PTR_LAST) begin
            rd_data <= mem_q[rd_ptr];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // icr_regfile

// ==== hw/icr_slave.sv ====
`timescale 1ns/1ns
// Functional notes
// - Slave only, standard rate, 7-bit address, 8-bit data bytes.
// - Bytes move in ascending order from byte zero; master may stop anytime.
// - Address is 1,1,strap,0,0,strap,strap; last bit high means read.
// - Write bytes load successive registers until a stop arrives.
// - Each byte is eight bits, MSB first, then one acknowledge bit.
// - The clock line is never held low by this device.
// - Access starts at byte zero after reset or a stop; offset bytes never move pointer.
// - Device drives data low across the acknowledge pulse after each byte it receives.
// - After start, compare address; only join the transfer on a match.
// - First byte after a write address is a filler and is discarded.
// - Pointer returns to byte zero when a block write completes.
// - Twelve bytes: status, result, control, disables, equaliser, threshold.
// - Byte zero is read-only live signal status, A0 at bit seven.
// - Status bit is 0 below idle threshold and 1 above it.
// - Byte one is read-only receiver load result, same channel order.
// - Byte two bits seven to four are active-low lane loopback controls.
// - Byte two bits three and two pick half-bit emphasis; low bits reserved.
// - Byte three holds per-channel input disables, reset to zero.
// - Loopback strap low selects loopback on all lanes at initialisation.
module icr_slave (
    input  wire logic           clock,
    input  wire logic           rst_n,
    input  wire logic           bus_clk,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe_n,
    output logic                scl_out,
    output logic                scl_oe_n,
    input  wire logic           addr_strap_high,
    input  wire logic           addr_strap_mid,
    input  wire logic           addr_strap_low,
    input  wire logic           loopback_strap_n,
    input  wire logic           group_a_half_bit_emph,
    input  wire logic           group_b_half_bit_emph,
    input  wire logic           restart_strap_n,
    input  wire logic           power_strap_n,
    input  wire logic           rxd_strap_a,
    input  wire logic           rxd_strap_b,
    input  wire logic [7:0]     grpa_strap,
    input  wire logic [7:0]     grpb_strap,
    input  wire logic [7:0]     channel_signal_bit,
    input  wire logic [7:0]     channel_load_bit,
    output logic      [3:0]     lane_loopback_n,
    output logic                group_a_emph_q,
    output logic                group_b_emph_q,
    output logic      [7:0]     channel_input_off_bit,
    output logic      [7:0]     channel_output_off,
    output logic      [7:0]     channel_restart_n,
    output logic      [7:0]     channel_power_n,
    output logic      [7:0]     receiver_detect_en,
    output logic      [7:0]     group_a_eq,
    output logic      [7:0]     group_b_eq,
    output logic      [7:0]     idle_threshold
);
    // Link side, clocked by the bus clock line itself.
    logic [2:0]             bit_q;
    logic [7:0]             shift_q;
    icr_pkg::icr_state_e    state_q;
    logic                   rd_mode_q;
    logic                   filler_q;
    logic                   drive_low_q;
    logic                   start_tgl_q;
    logic                   stop_tgl_q;
    logic                   start_seen_q;
    logic                   stop_seen_q;
    logic                   wr_tgl_q;
    logic                   nxt_tgl_q;
    logic [7:0]             wr_byte_q;
    logic [7:0]             tx_q;
    logic                   addr_hit;
    logic [6:0]             my_addr;

    // Main clock side.
    logic [7:0]             sig_s1_q, sig_s2_q, load_s1_q, load_s2_q;
    logic [2:0]             wr_s_q, nxt_s_q, stop_s_q;
    logic [icr_pkg::PTR_W-1:0] ptr_q;
    logic [7:0]             rd_data;
    logic [8*icr_pkg::NUM_BYTES-1:0] regs;
    logic [7:0]             init_loopback_emphasis_ctrl, init_restart, init_pwr, init_receiver_detect_enable;
    logic [7:0]             strap_s1_q [3];
    logic [7:0]             strap_s2_q [3];
    logic [7:0]             a_s1_q, a_s2_q, b_s1_q, b_s2_q;

    assign my_addr  = {icr_pkg::ADDR_HIGH_FIXED, addr_strap_high, icr_pkg::ADDR_MID_FIXED,
                       addr_strap_mid, addr_strap_low};
    assign addr_hit = (shift_q[7:1] == my_addr);

    // Start and stop are seen as data edges while the clock line is high.
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n)
            start_tgl_q <= 1'b0;
        else if (bus_clk)
            start_tgl_q <= ~start_tgl_q;
    end

    always_ff @(posedge sda_in or negedge rst_n) begin
        if (!rst_n)
            stop_tgl_q <= 1'b0;
        else if (bus_clk)
            stop_tgl_q <= ~stop_tgl_q;
    end

    // Bit sampling on the rising clock edge.
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q      <= 8'h00;
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
        end else begin
            start_seen_q <= start_tgl_q;
            stop_seen_q  <= stop_tgl_q;
            shift_q      <= {shift_q[6:0], sda_in};
        end
    end

    // Protocol state advances on the falling clock edge.
    always_ff @(negedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= icr_pkg::ICR_IDLE;
            bit_q       <= 3'h0;
            rd_mode_q   <= 1'b0;
            filler_q    <= 1'b0;
            drive_low_q <= 1'b0;
            wr_tgl_q    <= 1'b0;
            nxt_tgl_q   <= 1'b0;
            wr_byte_q   <= 8'h00;
            tx_q        <= 8'h00;
        end else if (start_seen_q != start_tgl_q) begin
            state_q     <= icr_pkg::ICR_ADDR;
            bit_q       <= 3'h0;
            drive_low_q <= 1'b0;
        end else if (stop_seen_q != stop_tgl_q) begin
            state_q     <= icr_pkg::ICR_IDLE;
            drive_low_q <= 1'b0;
        end else begin
            bit_q <= bit_q + 3'h1;
            unique case (state_q)
                icr_pkg::ICR_IDLE, icr_pkg::ICR_SKIP: begin
                    drive_low_q <= 1'b0;
                end
                icr_pkg::ICR_ADDR: begin
                    if (bit_q == icr_pkg::BIT_LAST) begin
                        if (addr_hit) begin
                            state_q     <= icr_pkg::ICR_ACK;
                            drive_low_q <= 1'b1;
                            rd_mode_q   <= shift_q[0];
                            filler_q    <= ~shift_q[0];
                        end else begin
                            state_q <= icr_pkg::ICR_SKIP;
                        end
                    end
                end
                icr_pkg::ICR_ACK: begin
                    bit_q <= 3'h0;
                    if (rd_mode_q) begin
                        state_q     <= icr_pkg::ICR_RTX;
                        tx_q        <= {rd_data[6:0], 1'b0};
                        drive_low_q <= ~rd_data[7];
                        nxt_tgl_q   <= ~nxt_tgl_q;
                    end else begin
                        state_q     <= icr_pkg::ICR_WRX;
                        drive_low_q <= 1'b0;
                    end
                end
                icr_pkg::ICR_WRX: begin
                    if (bit_q == icr_pkg::BIT_LAST) begin
                        state_q     <= icr_pkg::ICR_ACK;
                        drive_low_q <= 1'b1;
                        filler_q    <= 1'b0;
                        if (!filler_q) begin
                            wr_byte_q <= shift_q;
                            wr_tgl_q  <= ~wr_tgl_q;
                        end
                    end
                end
                icr_pkg::ICR_RTX: begin
                    if (bit_q == icr_pkg::BIT_LAST) begin
                        state_q     <= icr_pkg::ICR_RACK;
                        drive_low_q <= 1'b0;
                    end else begin
                        drive_low_q <= ~tx_q[7];
                        tx_q        <= {tx_q[6:0], 1'b0};
                    end
                end
                icr_pkg::ICR_RACK: begin
                    bit_q <= 3'h0;
                    if (!sda_in) begin
                        state_q     <= icr_pkg::ICR_RTX;
                        tx_q        <= {rd_data[6:0], 1'b0};
                        drive_low_q <= ~rd_data[7];
                        nxt_tgl_q   <= ~nxt_tgl_q;
                    end else begin
                        state_q <= icr_pkg::ICR_SKIP;
                    end
                end
            endcase
        end
    end

    // Open-drain data: drive low only, enable is active low.
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low_q;
    assign scl_out  = 1'b0;
    assign scl_oe_n = 1'b1;

    // Event toggles cross into the main clock by three-flop synchronisers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_s_q   <= 3'h0;
            nxt_s_q  <= 3'h0;
            stop_s_q <= 3'h0;
        end else begin
            wr_s_q   <= {wr_s_q[1:0], wr_tgl_q};
            nxt_s_q  <= {nxt_s_q[1:0], nxt_tgl_q};
            stop_s_q <= {stop_s_q[1:0], stop_tgl_q};
        end
    end

    // Pointer walks up per byte and returns to zero at each stop.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            ptr_q <= icr_pkg::PTR_SIG;
        else if (stop_s_q[2] != stop_s_q[1])
            ptr_q <= icr_pkg::PTR_SIG;
        else if ((wr_s_q[2] != wr_s_q[1]) || (nxt_s_q[2] != nxt_s_q[1]))
            ptr_q <= ptr_q + 4'h1;
    end

    // Status inputs and all straps except the address straps are synchronised before use.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sig_s1_q  <= 8'h00;
            sig_s2_q  <= 8'h00;
            load_s1_q <= 8'h00;
            load_s2_q <= 8'h00;
            a_s1_q    <= 8'h00;
            a_s2_q    <= 8'h00;
            b_s1_q    <= 8'h00;
            b_s2_q    <= 8'h00;
            strap_s1_q <= '{default: 8'h00};
            strap_s2_q <= '{default: 8'h00};
        end else begin
            sig_s1_q  <= channel_signal_bit;
            sig_s2_q  <= sig_s1_q;
            load_s1_q <= channel_load_bit;
            load_s2_q <= load_s1_q;
            a_s1_q    <= grpa_strap;
            a_s2_q    <= a_s1_q;
            b_s1_q    <= grpb_strap;
            b_s2_q    <= b_s1_q;
            strap_s1_q[0] <= {loopback_strap_n, group_a_half_bit_emph,
                              group_b_half_bit_emph, restart_strap_n, power_strap_n,
                              rxd_strap_a, rxd_strap_b, 1'b0};
            strap_s2_q <= strap_s1_q;
            strap_s1_q[1] <= 8'h00;
            strap_s1_q[2] <= 8'h00;
        end
    end

    // Straps are latched once, the cycle the synchronisers settle after reset.
    logic init_d;
    logic [1:0] init_cnt_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            init_cnt_q <= 2'h0;
        else if (init_cnt_q != 2'h3)
            init_cnt_q <= init_cnt_q + 2'h1;
    end
    assign init_d = (init_cnt_q == 2'h2);

    assign init_loopback_emphasis_ctrl    = {{4{strap_s2_q[0][7]}}, strap_s2_q[0][6], strap_s2_q[0][5],
                           2'h0};
    assign init_restart = {8{strap_s2_q[0][4]}};
    assign init_pwr     = {8{strap_s2_q[0][3]}};
    assign init_receiver_detect_enable    = {4{strap_s2_q[0][2], strap_s2_q[0][1]}};

    icr_regfile u_regs (
        .clock        (clock),
        .rst_n        (rst_n),
        .init         (init_d),
        .init_loopback_emphasis_ctrl    (init_loopback_emphasis_ctrl),
        .init_restart (init_restart),
        .init_pwr     (init_pwr),
        .init_receiver_detect_enable    (init_receiver_detect_enable),
        .init_grpa    (a_s2_q),
        .init_grpb    (b_s2_q),
        .wr           (wr_s_q[2] != wr_s_q[1]),
        .wr_ptr       (ptr_q),
        .wr_data      (wr_byte_q),
        .rd_ptr       (ptr_q),
        .sig_live     (sig_s2_q),
        .load_live    (load_s2_q),
        .rd_data      (rd_data),
        .regs         (regs)
    );

    // Control outputs are registered copies of the stored bytes.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lane_loopback_n       <= 4'h0;
            group_a_emph_q        <= 1'b0;
            group_b_emph_q        <= 1'b0;
            channel_input_off_bit <= icr_pkg::CHANNEL_INPUT_DISABLE_RESET;
            channel_output_off    <= icr_pkg::CHANNEL_OUTPUT_DISABLE_RESET;
            channel_restart_n     <= 8'h00;
            channel_power_n       <= 8'h00;
            receiver_detect_en    <= 8'h00;
            group_a_eq            <= 8'h00;
            group_b_eq            <= 8'h00;
            idle_threshold        <= icr_pkg::VTH_RESET;
        end else begin
            lane_loopback_n       <= regs[8*icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL+4 +: 4];
            group_a_emph_q        <= regs[8*icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL+3];
            group_b_emph_q        <= regs[8*icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL+2];
            channel_input_off_bit <= regs[8*icr_pkg::PTR_CHANNEL_INPUT_DISABLE +: 8];
            channel_output_off    <= regs[8*icr_pkg::PTR_CHANNEL_OUTPUT_DISABLE +: 8];
            channel_restart_n     <= regs[8*icr_pkg::PTR_RESTART +: 8];
            channel_power_n       <= regs[8*icr_pkg::PTR_PWR +: 8];
            receiver_detect_en    <= regs[8*icr_pkg::PTR_RECEIVER_DETECT_ENABLE +: 8];
            group_a_eq            <= regs[8*icr_pkg::PTR_GRPA +: 8];
            group_b_eq            <= regs[8*icr_pkg::PTR_GRPB +: 8];
            idle_threshold        <= regs[8*icr_pkg::PTR_VTH +: 8];
        end
    end

    no_clock_stretch_a: assert property (@(posedge clock) disable iff (!rst_n)
        scl_oe_n) else $error("clock line driven");
    ptr_zero_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
        (stop_s_q[2] != stop_s_q[1]) |=> ptr_q == icr_pkg::PTR_SIG)
        else $error("pointer not back at zero");
    ptr_step_a: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_s_q[2] != wr_s_q[1]) && (stop_s_q[2] == stop_s_q[1])
        |=> ptr_q == $past(ptr_q) + 4'h1) else $error("pointer did not step");
    ack_low_a: assert property (@(negedge bus_clk) disable iff (!rst_n)
        state_q == icr_pkg::ICR_ACK |-> !sda_oe_n) else $error("no ack");
    addr_miss_a: assert property (@(negedge bus_clk) disable iff (!rst_n)
        state_q == icr_pkg::ICR_SKIP |-> sda_oe_n) else $error("drove when idle");
    loopback_emphasis_ctrl_rsvd_a: assert property (@(posedge clock) disable iff (!rst_n)
        regs[8*icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL +: 2] == 2'h0) else $error("reserved bits");
    sig_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        ptr_q == icr_pkg::PTR_SIG && $stable(ptr_q) |=> rd_data == $past(sig_s2_q))
        else $error("status byte stale");
    loopback_out_a: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 lane_loopback_n == $past(regs[8*icr_pkg::PTR_LOOPBACK_EMPHASIS_CTRL+4 +: 4]))
        else $error("loopback output");
    wr_cov_c: cover property (@(posedge clock) wr_s_q[2] != wr_s_q[1]);
    rd_cov_c: cover property (@(posedge clock) nxt_s_q[2] != nxt_s_q[1]);
    stop_cov_c: cover property (@(posedge clock) stop_s_q[2] != stop_s_q[1]);
endmodule // icr_slave

// ==== tb/icr_master.sv ====
`timescale 1ns/1ns
// Bus master model: the clock idles high between frames and the data line is open-drain.
module icr_master (
    output logic        m_clk,
    output logic        m_low,
    input  wire logic   sda
);
    initial begin
        m_clk = 1'b1;
        m_low = 1'b0;
    end
    task automatic put_bit(input logic b);
        m_clk = 1'b0;
        #12 m_low = ~b;
        #12 m_clk = 1'b1;
        #24;
    endtask
    task automatic get_bit(output logic b);
        m_clk = 1'b0;
        #12 m_low = 1'b0;
        #12 m_clk = 1'b1;
        #12 b = sda;
        #12;
    endtask
    task automatic start;
        #24 m_low = 1'b1;
        #24;
    endtask
    task automatic stop;
        m_clk = 1'b0;
        #12 m_low = 1'b1;
        #12 m_clk = 1'b1;
        #24 m_low = 1'b0;
        #48;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    task automatic recv_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule // icr_master

// ==== tb/icr_slave_test.sv ====
`timescale 1ns/1ns
// Reaches the byte map through the master model and compares with a byte model.
module icr_slave_test;
    logic       clock, rst_n, m_clk, m_low, sda, bus_clk, sda_out, sda_oe_n, scl_out, scl_oe_n;
    logic [2:0] astrap;
    logic [6:0] ps;
    logic [7:0] grpa, grpb, sig, load, in_off, out_off, rs_o, pw_o, rx_o, eqa, eqb, vth, d;
    logic [3:0] lbo;
    logic       ea, eb, ack;
    int         n_mismatch, tests_run, cyc, seed, mdl[12];
    assign sda = ~(m_low | (~sda_oe_n & ~sda_out));
    assign bus_clk = m_clk & (scl_oe_n | scl_out);
    icr_master m_u (.m_clk(m_clk), .m_low(m_low), .sda(sda));
    icr_slave dut_u (
        .clock(clock), .rst_n(rst_n), .bus_clk(bus_clk), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .addr_strap_high(astrap[2]), .addr_strap_mid(astrap[1]), .addr_strap_low(astrap[0]),
        .loopback_strap_n(ps[6]), .group_a_half_bit_emph(ps[5]), .group_b_half_bit_emph(ps[4]),
        .restart_strap_n(ps[3]), .power_strap_n(ps[2]), .rxd_strap_a(ps[1]), .rxd_strap_b(ps[0]),
        .grpa_strap(grpa), .grpb_strap(grpb), .channel_signal_bit(sig), .channel_load_bit(load),
        .lane_loopback_n(lbo), .group_a_emph_q(ea), .group_b_emph_q(eb),
        .channel_input_off_bit(in_off), .channel_output_off(out_off), .channel_restart_n(rs_o),
        .channel_power_n(pw_o), .receiver_detect_en(rx_o), .group_a_eq(eqa), .group_b_eq(eqb),
        .idle_threshold(vth));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [7:0] adr(input logic rd);
        return {2'b11, astrap[2], 2'b00, astrap[1:0], rd};
    endfunction
    task automatic read_n(input int n);
        m_u.start();
        m_u.send_byte(adr(1'b1), ack);
        check("read address ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m_u.recv_byte(d, i == n - 1);
            check($sformatf("byte %0d", i), d & (i == 2 ? 8'hFC : 8'hFF), 8'(mdl[i]));
        end
        m_u.stop();
    endtask
    task automatic write_n(input int n);
        int v;
        m_u.start();
        m_u.send_byte(adr(1'b0), ack);
        check("write address ack", {7'h00, ack}, 8'h01);
        m_u.send_byte(8'h5A, ack);
        check("filler ack", {7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            v = $random(seed) & 255;
            m_u.send_byte(8'(v), ack);
            check("data ack", {7'h00, ack}, 8'h01);
            if (i == 2) mdl[2] = v & 8'hFC;
            else if (i > 2) mdl[i] = v;
        end
        m_u.stop();
    endtask
    initial begin
        seed = 30;
        rst_n = 1'b0;
        astrap = 3'($random(seed));
        ps = 7'($random(seed));
        grpa = 8'($random(seed));
        grpb = 8'($random(seed));
        sig = 8'($random(seed));
        load = 8'($random(seed));
        repeat (6) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        repeat (20) @(negedge clock);
        mdl = '{sig, load, {{4{ps[6]}}, ps[5], ps[4], 2'b00}, 0, 0, {8{ps[3]}}, {8{ps[2]}},
                {4{ps[1:0]}}, grpa, grpb, 0, 8'hEF};
        read_n(12);
        check("loopback out", {4'h0, lbo}, 8'(mdl[2] >> 4));
        check("input disable out", in_off, 8'h00);
        $display("test reset_values done");
        for (int k = 0; k < 7; k++) begin
            m_u.start();
            m_u.send_byte(adr(1'b1) ^ (8'h80 >> k), ack);
            check("foreign address ack", {7'h00, ack}, 8'h00);
            m_u.stop();
        end
        $display("test address_match done");
        write_n(12);
        read_n(12);
        check("input disable out", in_off, 8'(mdl[3]));
        check("emphasis out", {6'h00, ea, eb}, 8'(mdl[2] >> 2) & 8'h03);
        check("loopback out", {4'h0, lbo}, 8'(mdl[2] >> 4));
        check("threshold out", vth, 8'(mdl[11]));
        check("output disable out", out_off, 8'(mdl[4]));
        check("restart out", rs_o, 8'(mdl[5]));
        check("power down out", pw_o, 8'(mdl[6]));
        check("detect enable out", rx_o, 8'(mdl[7]));
        check("group a eq out", eqa, 8'(mdl[8]));
        check("group b eq out", eqb, 8'(mdl[9]));
        $display("test block_write done");
        write_n(4);
        read_n(4);
        $display("test partial_write done");
        @(negedge clock);
        sig = 8'($random(seed));
        load = 8'($random(seed));
        mdl[0] = sig;
        mdl[1] = load;
        repeat (10) @(negedge clock);
        read_n(2);
        check("clock never held", {5'h00, sda_out, scl_out, scl_oe_n}, 8'h01);
        $display("test live_status done");
        complete_run();
    end
endmodule // icr_slave_test
